//--- core/vipu_pkg.sv
// Constants of the vectored interrupt priority unit.
// Assumes one system clock; no other context needed.
package vipu_pkg;

   // ---------------------------------------------------------------
   // Source counts and flag indices
   // ---------------------------------------------------------------
   localparam int unsigned NUM_SOURCES  = 29;
   localparam int unsigned NUM_MASKABLE = 27;
   localparam int unsigned NUM_EXT      = 5;
   localparam logic [4:0]  IDX_WDT_MASK = 5'h00;
   localparam logic [4:0]  IDX_EXT4     = 5'h0A;
   localparam logic [4:0]  IDX_WT_TICK  = 5'h1A;
   localparam logic [4:0]  IDX_NMI      = 5'h1B;
   localparam logic [4:0]  IDX_BRK      = 5'h1C;

   // ---------------------------------------------------------------
   // Vector addresses
   // ---------------------------------------------------------------
   localparam logic [15:0] VEC_NMI = 16'h0004;
   localparam logic [15:0] VEC_BRK = 16'h003E;
   // Index is the default priority; 0 wins
   localparam logic [15:0] VEC_MASKABLE [NUM_MASKABLE] = '{
      16'h0006, 16'h0008, 16'h000A, 16'h000C, 16'h000E, 16'h0010,
      16'h0012, 16'h0014, 16'h0016, 16'h0018, 16'h0000, 16'h001A,
      16'h001C, 16'h001E, 16'h0020, 16'h0022, 16'h0024, 16'h0026,
      16'h0028, 16'h002A, 16'h002C, 16'h002E, 16'h0030, 16'h0032,
      16'h0034, 16'h0036, 16'h0000};

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [15:0] RST_VECTOR = 16'h0000;
   localparam logic [4:0]  RST_SEL    = 5'h00;

   typedef enum logic [1:0] {
      VIPU_IDLE  = 2'b01,
      VIPU_OFFER = 2'b10
   } vipu_state_t;

endpackage

//--- core/vipu_req_flag.sv
// One pending-request flag.
// Assumes set and clear are single-cycle pulses on the same clock.
`timescale 1ns/1ps
module vipu_req_flag (
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic set_pulse,
   input  wire logic clear_pulse,
   output logic      pending
);

   logic pend_ff;
   logic nxt_pend;

   // Set beats clear so an event in the service cycle survives
   always_comb begin
      nxt_pend = pend_ff;
      if (clear_pulse) begin
         nxt_pend = 1'b0;
      end
      if (set_pulse) begin
         nxt_pend = 1'b1;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pend_ff <= 1'b0;
      end else begin
         pend_ff <= nxt_pend;
      end
   end

   assign pending = pend_ff;

endmodule

//--- core/vipu_top.sv
// Vectored interrupt priority unit: latches requests, arbitrates,
// hands one vector at a time to the processor core.
// Assumes request inputs other than the edge pins are same-clock pulses.
//
// Contract
// - 29 sources: one NMI, 27 maskable, one software
// - Watchdog overflow in NMI mode vectors 0004H
// - Watchdog interval overflow: priority 0, vector 0006H
// - Simultaneous maskable requests: lowest priority number wins
// - Conversion done: priority 1, vector 0008H
// - Timer B overflow: priority 2, vector 000AH
// - Timer B matches: priorities 3-5, 000CH-0010H
// - Edge pins 0-3: priorities 6-9, 0012H-0018H
// - Serial done requests: priorities 15,16, 0022H,0024H
// - UART requests: priorities 17-19, 0026H-002AH
// - Timer A compares: priorities 20,21, 002CH,002EH
// - Byte timer matches: priorities 22,23, 0030H,0032H
// - Watch interval: priority 25, vector 0036H
`timescale 1ns/1ps
module vipu_top #(
   parameter logic [15:0] EXT4_VECTOR       = 16'h0038,
   parameter logic [15:0] WATCH_TICK_VECTOR = 16'h003A
) (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        wdt_nmi_select,
   input  wire logic        watchdog_overflow_request,
   input  wire logic        conversion_done_request,
   input  wire logic        timer_b_overflow_request,
   input  wire logic        timer_b_capture0_match_request,
   input  wire logic        timer_b_capture1_match_request,
   input  wire logic        timer_b_capture2_match_request,
   input  wire logic        ext_edge_request0,
   input  wire logic        ext_edge_request1,
   input  wire logic        ext_edge_request2,
   input  wire logic        ext_edge_request3,
   input  wire logic        ext_edge_request4,
   input  wire logic        can_error_request,
   input  wire logic        can_receive_request,
   input  wire logic        can_tx_buffer0_request,
   input  wire logic        can_tx_buffer1_request,
   input  wire logic        three_wire_done_request,
   input  wire logic        two_wire_done_request,
   input  wire logic        uart_rx_error_request,
   input  wire logic        uart_rx_done_request,
   input  wire logic        uart_tx_done_request,
   input  wire logic        timer_a_compare0_request,
   input  wire logic        timer_a_compare1_request,
   input  wire logic        byte_timer0_match_request,
   input  wire logic        byte_timer1_match_request,
   input  wire logic        nvm_write_done_request,
   input  wire logic        watch_interval_request,
   input  wire logic        watch_tick_request,
   input  wire logic        software_break_request,
   input  wire logic [26:0] request_mask,
   input  wire logic        core_int_enable,
   input  wire logic        vector_ack,
   output logic             vector_valid,
   output logic [15:0]      vector_addr,
   output logic [28:0]      pending_flags
);

   // ---------------------------------------------------------------
   // Edge pin synchronisers and rising-edge detect
   // ---------------------------------------------------------------
   logic [4:0] pin_meta_ff, pin_sync_ff, pin_prev_ff;
   logic [4:0] nxt_pin_meta, nxt_pin_sync, nxt_pin_prev;
   logic [4:0] pin_rise;

   always_comb begin
      nxt_pin_meta = {ext_edge_request4, ext_edge_request3,
                      ext_edge_request2, ext_edge_request1,
                      ext_edge_request0};
      nxt_pin_sync = pin_meta_ff;
      nxt_pin_prev = pin_sync_ff;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pin_meta_ff <= 5'h00;
         pin_sync_ff <= 5'h00;
         pin_prev_ff <= 5'h00;
      end else begin
         pin_meta_ff <= nxt_pin_meta;
         pin_sync_ff <= nxt_pin_sync;
         pin_prev_ff <= nxt_pin_prev;
      end
   end

   // Second and third stages are compared; the first is never looked at
   assign pin_rise = pin_sync_ff & ~pin_prev_ff;

   // ---------------------------------------------------------------
   // Request collection and pending flags
   // ---------------------------------------------------------------
   logic [28:0] set_req;
   logic [28:0] clr_req;
   logic [28:0] pend;

   always_comb begin
      set_req = {software_break_request,
                 watchdog_overflow_request & wdt_nmi_select,
                 watch_tick_request, watch_interval_request,
                 nvm_write_done_request,
                 byte_timer1_match_request,
                 byte_timer0_match_request,
                 timer_a_compare1_request,
                 timer_a_compare0_request,
                 uart_tx_done_request, uart_rx_done_request,
                 uart_rx_error_request,
                 two_wire_done_request,
                 three_wire_done_request,
                 can_tx_buffer1_request, can_tx_buffer0_request,
                 can_receive_request, can_error_request,
                 pin_rise,
                 timer_b_capture2_match_request,
                 timer_b_capture1_match_request,
                 timer_b_capture0_match_request,
                 timer_b_overflow_request,
                 conversion_done_request,
                 watchdog_overflow_request & ~wdt_nmi_select};
   end

   genvar g;
   generate
      for (g = 0; g < vipu_pkg::NUM_SOURCES; g++) begin : g_flag
         vipu_req_flag u_flag (
            .clock       (clock),
            .rst         (rst),
            .set_pulse   (set_req[g]),
            .clear_pulse (clr_req[g]),
            .pending     (pend[g])
         );
      end
   endgenerate

   assign pending_flags = pend;

   // ---------------------------------------------------------------
   // Arbitration and vector hand-over
   // ---------------------------------------------------------------
   vipu_pkg::vipu_state_t state_ff, nxt_state;
   logic [4:0]  sel_ff, nxt_sel;
   logic [15:0] vec_ff, nxt_vec;
   logic [26:0] eligible;

   function automatic logic [15:0] maskable_vec(input logic [4:0] idx);
      logic [15:0] v;
      v = vipu_pkg::VEC_MASKABLE[idx];
      if (idx == vipu_pkg::IDX_EXT4) begin
         v = EXT4_VECTOR;
      end else if (idx == vipu_pkg::IDX_WT_TICK) begin
         v = WATCH_TICK_VECTOR;
      end
      return v;
   endfunction

   // Mask and global enable gate maskable flags only
   assign eligible = pend[26:0] & ~request_mask
                     & {27{core_int_enable}};

   always_comb begin
      nxt_state = state_ff;
      nxt_sel   = sel_ff;
      nxt_vec   = vec_ff;
      clr_req   = '0;
      case (state_ff)
         vipu_pkg::VIPU_IDLE: begin
            if (pend[vipu_pkg::IDX_NMI]) begin
               nxt_sel   = vipu_pkg::IDX_NMI;
               nxt_vec   = vipu_pkg::VEC_NMI;
               nxt_state = vipu_pkg::VIPU_OFFER;
            end else if (pend[vipu_pkg::IDX_BRK]) begin
               nxt_sel   = vipu_pkg::IDX_BRK;
               nxt_vec   = vipu_pkg::VEC_BRK;
               nxt_state = vipu_pkg::VIPU_OFFER;
            end else if (|eligible) begin
               // Downward scan leaves the smallest number in place
               for (int i = 26; i >= 0; i--) begin
                  if (eligible[i]) begin
                     nxt_sel = 5'(i);
                  end
               end
               nxt_vec   = maskable_vec(nxt_sel);
               nxt_state = vipu_pkg::VIPU_OFFER;
            end
         end
         vipu_pkg::VIPU_OFFER: begin
            // Committed once offered; later masking does not retract
            if (vector_ack) begin
               clr_req[sel_ff] = 1'b1;
               nxt_state       = vipu_pkg::VIPU_IDLE;
            end
         end
         default: begin
            nxt_state = vipu_pkg::VIPU_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_ff <= vipu_pkg::VIPU_IDLE;
         sel_ff   <= vipu_pkg::RST_SEL;
         vec_ff   <= vipu_pkg::RST_VECTOR;
      end else begin
         state_ff <= nxt_state;
         sel_ff   <= nxt_sel;
         vec_ff   <= nxt_vec;
      end
   end

   assign vector_valid = (state_ff == vipu_pkg::VIPU_OFFER);
   assign vector_addr  = vec_ff;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   brk_vector_a: assert property (
      vector_valid && sel_ff == 5'h1C |-> vector_addr == 16'h003E)
      else $error("software break vector wrong");

   nmi_path_a: assert property (
      watchdog_overflow_request && wdt_nmi_select && !vector_valid
      |=> ##1 vector_valid && vector_addr == 16'h0004)
      else $error("watchdog NMI not offered at 0004H");

   wdt_mask_a: assert property (
      watchdog_overflow_request && !wdt_nmi_select
      |=> pend[0] && !$rose(pend[27]))
      else $error("interval watchdog not pending as priority 0");

   prio_order_a: assert property (
      $rose(vector_valid) && sel_ff < 5'd27
      |-> ($past(eligible) & ((27'h1 << sel_ff) - 27'h1)) == 27'h0)
      else $error("higher priority request was passed over");

   ad_vector_a: assert property (
      vector_valid && sel_ff == 5'd1 |-> vector_addr == 16'h0008)
      else $error("conversion vector wrong");

   ovf_vector_a: assert property (
      vector_valid && sel_ff == 5'd2 |-> vector_addr == 16'h000A)
      else $error("timer b overflow vector wrong");

   capture_vector_a: assert property (
      vector_valid && sel_ff inside {[5'd3:5'd5]}
      |-> vector_addr == 16'h000C + {10'h000, sel_ff - 5'd3, 1'b0})
      else $error("timer b match vector wrong");

   edge_vector_a: assert property (
      vector_valid && sel_ff inside {[5'd6:5'd9]}
      |-> vector_addr == 16'h0012 + {10'h000, sel_ff - 5'd6, 1'b0})
      else $error("edge pin vector wrong");

   serial_vector_a: assert property (
      vector_valid && sel_ff inside {5'd15, 5'd16}
      |-> vector_addr == 16'h0022 + {10'h000, sel_ff - 5'd15, 1'b0})
      else $error("serial done vector wrong");

   uart_vector_a: assert property (
      vector_valid && sel_ff inside {[5'd17:5'd19]}
      |-> vector_addr == 16'h0026 + {10'h000, sel_ff - 5'd17, 1'b0})
      else $error("uart vector wrong");

   compare_vector_a: assert property (
      vector_valid && sel_ff inside {5'd20, 5'd21}
      |-> vector_addr == 16'h002C + {10'h000, sel_ff - 5'd20, 1'b0})
      else $error("timer a compare vector wrong");

   byte_vector_a: assert property (
      vector_valid && sel_ff inside {5'd22, 5'd23}
      |-> vector_addr == 16'h0030 + {10'h000, sel_ff - 5'd22, 1'b0})
      else $error("byte timer vector wrong");

   watch_vector_a: assert property (
      vector_valid && sel_ff == 5'd25 |-> vector_addr == 16'h0036)
      else $error("watch interval vector wrong");

   ack_clear_a: assert property (
      vector_valid && vector_ack && !set_req[sel_ff]
      |=> !vector_valid && !pend[$past(sel_ff)])
      else $error("serviced flag not cleared");

endmodule

//--- dv/vipu_core_model.sv
// Processor core side: takes each offered vector after a set delay.
// Assumes the unit's offer/ack handshake on one rising-edge clock.
`timescale 1ns/1ps
module vipu_core_model (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        vector_valid,
   input  wire logic [15:0] vector_addr,
   input  wire logic [3:0]  ack_wait,
   output logic             vector_ack,
   output logic [15:0]      taken_vec,
   output int               taken_count
);
   logic [3:0] wait_ff;

   // Ack is one cycle; the vector is taken at the edge that samples it
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         vector_ack  <= 1'b0;
         wait_ff     <= 4'h0;
         taken_vec   <= 16'h0000;
         taken_count <= 0;
      end else if (vector_ack) begin
         vector_ack  <= 1'b0;
         wait_ff     <= 4'h0;
         taken_vec   <= vector_addr;
         taken_count <= taken_count + 1;
      end else if (vector_valid && wait_ff == ack_wait) begin
         vector_ack <= 1'b1;
      end else if (vector_valid) begin
         wait_ff <= wait_ff + 4'h1;
      end
   end
endmodule

//--- dv/vipu_top_tb_top.sv
// Self-checking bench for the vectored interrupt priority unit.
// Assumes vipu_core_model answers every offer of the unit.
`timescale 1ns/1ps
module vipu_top_tb_top;
   localparam logic [15:0] EXT4_V = 16'h0040;
   localparam logic [15:0] TICK_V = 16'h0042;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        nmi_sel = 1'b0;
   logic        int_en = 1'b1;
   logic [28:0] req = '0;
   logic [26:0] mask = '0;
   logic [3:0]  ack_wait = 4'h0;
   logic        vector_ack;
   logic        vector_valid;
   logic [15:0] vector_addr;
   logic [15:0] taken_vec;
   logic [28:0] pending_flags;
   int          taken_count;
   int          seen = 0;
   int          bad_count = 0;
   int          tests_run = 0;
   int          cycles = 0;

   vipu_top #(.EXT4_VECTOR(EXT4_V), .WATCH_TICK_VECTOR(TICK_V)) dut_u (
      .clock(clock), .rst(rst), .wdt_nmi_select(nmi_sel),
      .watchdog_overflow_request(req[0]),
      .conversion_done_request(req[1]),
      .timer_b_overflow_request(req[2]),
      .timer_b_capture0_match_request(req[3]),
      .timer_b_capture1_match_request(req[4]),
      .timer_b_capture2_match_request(req[5]),
      .ext_edge_request0(req[6]), .ext_edge_request1(req[7]),
      .ext_edge_request2(req[8]), .ext_edge_request3(req[9]),
      .ext_edge_request4(req[10]), .can_error_request(req[11]),
      .can_receive_request(req[12]), .can_tx_buffer0_request(req[13]),
      .can_tx_buffer1_request(req[14]),
      .three_wire_done_request(req[15]), .two_wire_done_request(req[16]),
      .uart_rx_error_request(req[17]), .uart_rx_done_request(req[18]),
      .uart_tx_done_request(req[19]),
      .timer_a_compare0_request(req[20]),
      .timer_a_compare1_request(req[21]),
      .byte_timer0_match_request(req[22]),
      .byte_timer1_match_request(req[23]),
      .nvm_write_done_request(req[24]), .watch_interval_request(req[25]),
      .watch_tick_request(req[26]), .software_break_request(req[28]),
      .request_mask(mask), .core_int_enable(int_en),
      .vector_ack(vector_ack), .vector_valid(vector_valid),
      .vector_addr(vector_addr), .pending_flags(pending_flags));

   vipu_core_model core_u (
      .clock(clock), .rst(rst), .vector_valid(vector_valid),
      .vector_addr(vector_addr), .ack_wait(ack_wait),
      .vector_ack(vector_ack), .taken_vec(taken_vec),
      .taken_count(taken_count));

   always #10 clock = ~clock;

   // Whole run needs well under 1500 cycles; a hang stops at 4000
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         bad_count++;
         test_done();
      end
   end

   // ----
   // Helpers
   // ----
   function automatic logic [15:0] expv(input int p);
      if (p == 10)
         return EXT4_V;
      if (p == 26)
         return TICK_V;
      // Vector 0x0036 at priority 25, two bytes apart, none at 10
      return (p < 10) ? 16'h0006 + 16'(2 * p) : 16'h0004 + 16'(2 * p);
   endfunction

   task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_flags(input logic [28:0] got, input logic [28:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic pulse(input logic [28:0] bits);
      @(posedge clock);
      req <= bits;
      @(posedge clock);
      req <= '0;
      #1;
   endtask

   task automatic get_vec(input logic [15:0] exp);
      for (int i = 0; i < 40 && taken_count == seen; i++) begin
         @(posedge clock);
         #1;
      end
      // No offer taken in time shows as an impossible vector
      if (taken_count == seen)
         chk_vec(16'hFFFF, exp);
      else
         chk_vec(taken_vec, exp);
      seen = taken_count;
   endtask

   // ----
   // Scenarios
   // ----
   task automatic t_reset;
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      #1;
      chk_flags(pending_flags, '0);
      chk_vec(vector_addr, 16'h0000);
      chk_vec({15'h0000, vector_valid}, 16'h0000);
   endtask

   task automatic each_src(input int lo, input int hi);
      for (int p = lo; p <= hi; p++) begin
         pulse(29'h1 << p);
         if (p < 6 || p > 10)
            chk_flags(pending_flags, 29'h1 << p);
         get_vec(expv(p));
         chk_flags(pending_flags, '0);
      end
   endtask

   task automatic t_prio;
      @(posedge clock);
      mask <= '1;
      ack_wait <= 4'h2;
      pulse({2'b00, {27{1'b1}}});
      repeat (8) @(posedge clock);
      #1;
      chk_flags(pending_flags, {2'b00, {27{1'b1}}});
      chk_vec({15'h0000, vector_valid}, 16'h0000);
      @(posedge clock);
      mask <= '0;
      for (int p = 0; p < 27; p++)
         get_vec(expv(p));
   endtask

   task automatic t_nmi;
      @(posedge clock);
      int_en <= 1'b0;
      nmi_sel <= 1'b1;
      pulse(29'h10000003);
      get_vec(16'h0004);
      get_vec(16'h003E);
      // Second request while still pending must merge
      pulse(29'h00000002);
      repeat (8) @(posedge clock);
      #1;
      chk_flags(pending_flags, 29'h00000002);
      chk_vec({15'h0000, vector_valid}, 16'h0000);
      @(posedge clock);
      int_en <= 1'b1;
      nmi_sel <= 1'b0;
      get_vec(16'h0008);
      repeat (6) @(posedge clock);
      #1;
      chk_vec(16'(taken_count - seen), 16'h0000);
   endtask

   // New event in the ack cycle must leave its flag pending
   task automatic t_race;
      @(posedge clock);
      ack_wait <= 4'h0;
      pulse(29'h00000002);
      repeat (2) @(posedge clock);
      req <= 29'h00000002;
      @(posedge clock);
      req <= '0;
      #1;
      get_vec(16'h0008);
      chk_flags(pending_flags, 29'h00000002);
      get_vec(16'h0008);
      chk_flags(pending_flags, '0);
   endtask

   task automatic test_done;
      $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      t_reset();
      each_src(0, 5);
      each_src(6, 10);
      each_src(11, 19);
      each_src(20, 26);
      t_prio();
      t_nmi();
      t_race();
      test_done();
   end
endmodule
